/* verilog/adg_core.sv */
// Notes on behaviour
// - Each generator keeps four pointers for indirect addressing.
// - A used pointer is afterwards advanced by a selected modify value.
// - A nonzero length per pointer turns on circular wrapping.
// - First generator addresses data memory only, with optional bit reverse.
// - Second generator addresses data or program memory, no bit reverse.
// - Both generators can issue addresses in the same cycle.
// - Program data access and instruction fetch share one cycle.
// - Program writes take the low eight bits from the byte extension.
// - Program data reads put their low eight bits in the byte extension.
// - Serial port word transfers use circular addressing without instructions.
// - One or two pointers and data moves can happen per cycle.

`include "adg_cfg.svh"

module adg_core
    import adg_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                arst_n,

    // Register load from the core (generator 0 or 1)
    input  wire logic                ld_en,
    input  wire logic                ld_gen,
    input  wire adg_kind_e           ld_kind,
    input  wire logic [`ADG_IW-1:0]  ld_idx,
    input  wire adg_addr_t           ld_data,

    // Register readback
    input  wire logic                rd_gen,
    input  wire adg_kind_e           rd_kind,
    input  wire logic [`ADG_IW-1:0]  rd_idx,
    output adg_addr_t                rd_data_q,

    // Data-only generator request
    input  wire logic                a_use,
    input  wire logic [`ADG_IW-1:0]  a_ptr,
    input  wire logic [`ADG_IW-1:0]  a_mod,
    input  wire logic                a_brev,
    input  wire logic                a_we,

    // Dual-space generator request
    input  wire logic                b_use,
    input  wire logic [`ADG_IW-1:0]  b_ptr,
    input  wire logic [`ADG_IW-1:0]  b_mod,
    input  wire logic                b_space,
    input  wire logic                b_we,

    // Serial port automatic transfer request
    input  wire logic                ab_req,
    input  wire logic [`ADG_IW-1:0]  ab_ptr,
    input  wire logic [`ADG_IW-1:0]  ab_mod,
    input  wire logic                ab_we,
    output logic                     ab_grant_q,

    // Instruction fetch address from the sequencer
    input  wire logic                fetch_en,
    input  wire adg_addr_t           fetch_addr,

    // Core write data and byte extension load
    input  wire logic [`ADG_DW-1:0]  core_wdata,
    input  wire logic                px_ld,
    input  wire logic [`ADG_XW-1:0]  px_ld_data,
    output logic [`ADG_XW-1:0]       pm_low_byte_ext_q,

    // Program memory read data (one cycle after the request)
    input  wire logic [`ADG_PW-1:0]  pm_rdata,

    // Data memory port of the data-only generator
    output adg_addr_t                dm_a_addr_q,
    output logic                     dm_a_en_q,
    output logic                     dm_a_we_q,

    // Data memory port of the dual-space generator
    output adg_addr_t                dm_b_addr_q,
    output logic                     dm_b_en_q,
    output logic                     dm_b_we_q,

    // Program memory data port
    output adg_addr_t                pm_address_bus_q,
    output logic                     pm_en_q,
    output logic                     pm_we_q,
    output logic [`ADG_PW-1:0]       pm_wdata_q,

    // Program memory instruction port
    output adg_addr_t                pm_ins_addr_q,
    output logic                     pm_ins_en_q,

    // Program data returned to the core
    output logic [`ADG_DW-1:0]       pm_data_q,
    output logic                     pm_data_vld_q
);

    ////////////////////////////////////////////////////////////////////////
    // Request steering

    logic                 g0_use;
    logic [`ADG_IW-1:0]   g0_ptr;
    logic [`ADG_IW-1:0]   g0_mod;
    logic                 g0_brev;
    logic                 ab_take;
    logic                 g0_ld;
    logic                 g1_ld;
    adg_addr_t            g0_addr;
    adg_addr_t            g1_addr;
    adg_addr_t            g0_rd;
    adg_addr_t            g1_rd;
    logic                 pm_rd_pend_q;

    // Serial transfers borrow the data-only generator when the core does not use it (a_use low)
    assign ab_take = ab_req && !a_use;
    assign g0_use  = a_use || ab_take;
    assign g0_ptr  = a_use ? a_ptr : ab_ptr;
    assign g0_mod  = a_use ? a_mod : ab_mod;
    assign g0_brev = a_use && a_brev;

    // Load strobes per generator
    assign g0_ld = ld_en && !ld_gen;
    assign g1_ld = ld_en && ld_gen;

    ////////////////////////////////////////////////////////////////////////
    // Address generators

    // Data-only generator, bit reverse available
    adg_agen #(
        .BREV_OK (1'b1)
    ) u_data_only_addr_gen (
        .clk     (clk),
        .arst_n  (arst_n),
        .ld_en   (g0_ld),
        .ld_kind (ld_kind),
        .ld_idx  (ld_idx),
        .ld_data (ld_data),
        .use_en  (g0_use),
        .use_ptr (g0_ptr),
        .use_mod (g0_mod),
        .brev_en (g0_brev),
        .addr    (g0_addr),
        .rd_kind (rd_kind),
        .rd_idx  (rd_idx),
        .rd_data (g0_rd)
    );

    // Dual-space generator, no bit reverse
    adg_agen #(
        .BREV_OK (1'b0)
    ) u_dual_space_addr_gen (
        .clk     (clk),
        .arst_n  (arst_n),
        .ld_en   (g1_ld),
        .ld_kind (ld_kind),
        .ld_idx  (ld_idx),
        .ld_data (ld_data),
        .use_en  (b_use),
        .use_ptr (b_ptr),
        .use_mod (b_mod),
        .brev_en (1'b0),
        .addr    (g1_addr),
        .rd_kind (rd_kind),
        .rd_idx  (rd_idx),
        .rd_data (g1_rd)
    );

    ////////////////////////////////////////////////////////////////////////
    // Readback register

    // Registered readback of the selected generator entry
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_q <= `ADG_RST_ADDR;
        end else begin
            rd_data_q <= rd_gen ? g1_rd : g0_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data memory ports

    // Data-only generator drives its own data memory port
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dm_a_addr_q <= `ADG_RST_ADDR;
            dm_a_en_q   <= 1'b0;
            dm_a_we_q   <= 1'b0;
            ab_grant_q  <= 1'b0;
        end else begin
            dm_a_addr_q <= g0_addr;
            dm_a_en_q   <= g0_use;
            dm_a_we_q   <= a_use ? a_we : (ab_take && ab_we);
            ab_grant_q  <= ab_take;
        end
    end

    // Dual-space generator aimed at data memory
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dm_b_addr_q <= `ADG_RST_ADDR;
            dm_b_en_q   <= 1'b0;
            dm_b_we_q   <= 1'b0;
        end else begin
            dm_b_addr_q <= g1_addr;
            dm_b_en_q   <= b_use && b_space == `ADG_SPC_DM;
            dm_b_we_q   <= b_use && b_space == `ADG_SPC_DM && b_we;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program memory ports

    // Program data access from the dual-space generator
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pm_address_bus_q <= `ADG_RST_ADDR;
            pm_en_q          <= 1'b0;
            pm_we_q          <= 1'b0;
            pm_wdata_q       <= `ADG_RST_PW;
        end else begin
            pm_address_bus_q <= g1_addr;
            pm_en_q          <= b_use && b_space == `ADG_SPC_PM;
            pm_we_q          <= b_use && b_space == `ADG_SPC_PM && b_we;
            pm_wdata_q       <= {core_wdata, pm_low_byte_ext_q};
        end
    end

    // Instruction port runs beside the data port
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pm_ins_addr_q <= `ADG_RST_ADDR;
            pm_ins_en_q   <= 1'b0;
        end else begin
            pm_ins_addr_q <= fetch_addr;
            pm_ins_en_q   <= fetch_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program data return and byte extension

    // Marks the cycle in which program read data is on pm_rdata
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pm_rd_pend_q <= 1'b0;
        end else begin
            pm_rd_pend_q <= pm_en_q && !pm_we_q;
        end
    end

    // Upper sixteen bits of a program data read go to the core
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pm_data_q     <= `ADG_RST_WORD;
            pm_data_vld_q <= 1'b0;
        end else begin
            pm_data_vld_q <= pm_rd_pend_q;
            if (pm_rd_pend_q) begin
                pm_data_q <= pm_rdata[`ADG_WHI:`ADG_WLO];
            end
        end
    end

    // Byte extension: a read return wins over a core load
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pm_low_byte_ext_q <= `ADG_RST_BYTE;
        end else if (pm_rd_pend_q) begin
            pm_low_byte_ext_q <= pm_rdata[`ADG_XHI:`ADG_XLO];
        end else if (px_ld) begin
            pm_low_byte_ext_q <= px_ld_data;
        end
    end

endmodule : adg_core

/* verilog/adg_cfg.svh */
`ifndef ADG_CFG_SVH
`define ADG_CFG_SVH

// Address, data and program word widths
`define ADG_AW        14
`define ADG_DW        16
`define ADG_PW        24
`define ADG_XW        8

// Pointers, modifiers and lengths per generator
`define ADG_NREG      4
`define ADG_IW        2

// Reset value of every pointer, modify, length and base entry
`define ADG_RST_ADDR  14'h0000
// Reset value of the program-memory low byte extension
`define ADG_RST_BYTE  8'h00
// Reset value of the 16-bit data returned to the core
`define ADG_RST_WORD  16'h0000
// Reset value of the 24-bit program write word
`define ADG_RST_PW    24'h000000
// Length value that turns modulo wrapping off
`define ADG_LEN_OFF   14'h0000

// Sign bit of a modify value
`define ADG_MSB       13
// Low byte field of a program-memory word
`define ADG_XLO       0
`define ADG_XHI       7
// High word field of a program-memory word
`define ADG_WLO       8
`define ADG_WHI       23

// Memory space select of the dual-space generator
`define ADG_SPC_DM    1'b0
`define ADG_SPC_PM    1'b1

`endif

/* verilog/adg_pkg.sv */
`include "adg_cfg.svh"

package adg_pkg;

    // One address word
    typedef logic [`ADG_AW-1:0] adg_addr_t;

    // Which register bank of a generator is loaded or read
    typedef enum logic [1:0] {
        ADG_KIND_PTR = 2'h0,
        ADG_KIND_MOD = 2'h1,
        ADG_KIND_LEN = 2'h3
    } adg_kind_e;

endpackage : adg_pkg

/* verilog/adg_agen.sv */
`include "adg_cfg.svh"

module adg_agen
    import adg_pkg::*;
#(
    parameter bit BREV_OK = 1'b0
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              ld_en,
    input  wire adg_kind_e         ld_kind,
    input  wire logic [`ADG_IW-1:0] ld_idx,
    input  wire adg_addr_t         ld_data,
    input  wire logic              use_en,
    input  wire logic [`ADG_IW-1:0] use_ptr,
    input  wire logic [`ADG_IW-1:0] use_mod,
    input  wire logic              brev_en,
    output adg_addr_t              addr,
    input  wire adg_kind_e         rd_kind,
    input  wire logic [`ADG_IW-1:0] rd_idx,
    output adg_addr_t              rd_data
);

    adg_addr_t   ptr_q  [`ADG_NREG];
    adg_addr_t   mod_q  [`ADG_NREG];
    adg_addr_t   len_q  [`ADG_NREG];
    adg_addr_t   base_q [`ADG_NREG];
    adg_addr_t   cur;
    adg_addr_t   rev;
    adg_addr_t   nxt_d;
    logic [15:0] sum;
    logic [15:0] top;

    // Pointer in use and its bit-reversed form
    assign cur = ptr_q[use_ptr];
    for (genvar b = 0; b < `ADG_AW; b++) begin : g_rev
        assign rev[b] = cur[`ADG_AW-1-b];
    end
    assign addr = (BREV_OK && brev_en) ? rev : cur;

    // Post-modify sum with circular wrap inside base to base plus length
    always_comb begin
        sum   = {2'b00, cur} + {{2{mod_q[use_mod][`ADG_MSB]}}, mod_q[use_mod]};
        top   = {2'b00, base_q[use_ptr]} + {2'b00, len_q[use_ptr]};
        if (len_q[use_ptr] != `ADG_LEN_OFF) begin
            if (!mod_q[use_mod][`ADG_MSB] && (sum >= top)) begin
                sum = sum - {2'b00, len_q[use_ptr]};
            end else if (mod_q[use_mod][`ADG_MSB]
                         && (sum[15] || sum < {2'b00, base_q[use_ptr]})) begin
                sum = sum + {2'b00, len_q[use_ptr]};
            end
        end
        nxt_d = sum[`ADG_AW-1:0];
    end

    // Per entry: pointer, base, modify and length registers
    for (genvar g = 0; g < `ADG_NREG; g++) begin : g_ent
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                ptr_q[g]  <= `ADG_RST_ADDR;
                base_q[g] <= `ADG_RST_ADDR;
            end else if (ld_en && ld_idx == g && ld_kind == ADG_KIND_PTR) begin
                ptr_q[g]  <= ld_data;
                base_q[g] <= ld_data;
            end else if (use_en && use_ptr == g) begin
                ptr_q[g]  <= nxt_d;
            end
        end

        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                mod_q[g] <= `ADG_RST_ADDR;
                len_q[g] <= `ADG_RST_ADDR;
            end else if (ld_en && ld_idx == g) begin
                if (ld_kind == ADG_KIND_MOD) begin
                    mod_q[g] <= ld_data;
                end
                if (ld_kind == ADG_KIND_LEN) begin
                    len_q[g] <= ld_data;
                end
            end
        end
    end

    // Register readback
    always_comb begin
        unique case (rd_kind)
            ADG_KIND_PTR: rd_data = ptr_q[rd_idx];
            ADG_KIND_MOD: rd_data = mod_q[rd_idx];
            ADG_KIND_LEN: rd_data = len_q[rd_idx];
            default:      rd_data = `ADG_RST_ADDR;
        endcase
    end

endmodule : adg_agen

/* testbench/adg_core_props.sv */
`include "adg_cfg.svh"

module adg_core_props
    import adg_pkg::*;
(
    input wire logic               clk,
    input wire logic               arst_n,
    input wire logic               a_use,
    input wire logic               a_we,
    input wire logic               ab_req,
    input wire logic               b_use,
    input wire logic               b_space,
    input wire logic               b_we,
    input wire logic               fetch_en,
    input wire adg_addr_t          fetch_addr,
    input wire logic [`ADG_DW-1:0] core_wdata,
    input wire logic [`ADG_PW-1:0] pm_rdata,
    input wire logic [`ADG_XW-1:0] pm_low_byte_ext_q,
    input wire logic               dm_a_en_q,
    input wire logic               dm_a_we_q,
    input wire logic               dm_b_en_q,
    input wire logic               dm_b_we_q,
    input wire logic               pm_en_q,
    input wire logic               pm_we_q,
    input wire logic [`ADG_PW-1:0] pm_wdata_q,
    input wire logic               pm_ins_en_q,
    input wire adg_addr_t          pm_ins_addr_q,
    input wire logic [`ADG_DW-1:0] pm_data_q,
    input wire logic               pm_data_vld_q,
    input wire logic               ab_grant_q
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////
    a_dm_a_strobe: assert property (
        dm_a_en_q == $past(a_use || ab_req))
        else $error("data-only port strobe wrong");
    a_dm_a_write: assert property (
        a_use |=> dm_a_we_q == $past(a_we))
        else $error("data-only write marker wrong");
    a_serial_grant: assert property (
        ab_grant_q == $past(ab_req && !a_use))
        else $error("serial grant wrong");
    a_gen0_no_pm: assert property (
        !b_use |=> !pm_en_q)
        else $error("program port used without dual-space request");
    a_b_to_dm: assert property (
        b_use && !b_space |=> dm_b_en_q && !pm_en_q)
        else $error("dual-space data access misrouted");
    a_dm_b_write: assert property (
        b_use && !b_space |=> dm_b_we_q == $past(b_we))
        else $error("dual-space data write marker wrong");
    a_dual_fetch: assert property (
        a_use && b_use && b_space |=> dm_a_en_q && pm_en_q)
        else $error("dual operand fetch lost");
    a_fetch_with_op: assert property (
        fetch_en && b_use && b_space
        |=> pm_ins_en_q && pm_en_q && pm_ins_addr_q == $past(fetch_addr))
        else $error("fetch and program data not in one cycle");
    a_pm_wr_word: assert property (
        b_use && b_space && b_we |=> pm_we_q
        && pm_wdata_q == {$past(core_wdata), $past(pm_low_byte_ext_q)})
        else $error("program write word wrong");
    a_pm_rd_ext: assert property (
        pm_en_q && !pm_we_q |-> ##2 pm_data_vld_q
        && pm_low_byte_ext_q == $past(pm_rdata[7:0])
        && pm_data_q == $past(pm_rdata[23:8]))
        else $error("program read split wrong");
endmodule : adg_core_props

/* testbench/adg_pm_model.sv */
`include "adg_cfg.svh"

module adg_pm_model
    import adg_pkg::*;
(
    input wire logic               clk,
    input wire adg_addr_t          pm_address_bus_q,
    input wire logic               pm_en_q,
    input wire logic               pm_we_q,
    input wire logic [`ADG_PW-1:0] pm_wdata_q,
    output logic [`ADG_PW-1:0]     pm_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [`ADG_PW-1:0] mem [0:16383];

    // Preload with an address pattern so stale reads are visible
    initial begin
        pm_rdata = 24'h5a5a5a;
        for (int i = 0; i < 16384; i++) begin
            mem[i] = {i[9:0], ~i[13:0]};
        end
    end

    // Store writes; read data valid one cycle, garbage otherwise
    always @(posedge clk) begin
        if (pm_en_q && pm_we_q) begin
            mem[pm_address_bus_q] <= pm_wdata_q;
        end
        pm_rdata <= (pm_en_q && !pm_we_q) ? mem[pm_address_bus_q] : ~pm_rdata;
    end
endmodule : adg_pm_model

/* testbench/dual_address_generator_bench.sv */
`include "adg_cfg.svh"

module dual_address_generator_bench
    import adg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [1:0] p;
        logic [1:0] m;
        logic       b;
        adg_addr_t  e;
    } adg_row_s;

    logic clk, arst_n, ld_en, ld_gen, rd_gen, a_use, a_brev, a_we;
    logic b_use, b_space, b_we, ab_req, ab_we, fetch_en, px_ld;
    adg_kind_e ld_kind, rd_kind;
    logic [1:0] ld_idx, rd_idx, a_ptr, a_mod, b_ptr, b_mod, ab_ptr, ab_mod;
    adg_addr_t ld_data, fetch_addr, rd_data_q, dm_a_addr_q, dm_b_addr_q;
    adg_addr_t pm_address_bus_q, pm_ins_addr_q;
    logic [15:0] core_wdata, pm_data_q;
    logic [7:0] px_ld_data, pm_low_byte_ext_q;
    logic [23:0] pm_rdata, pm_wdata_q;
    logic ab_grant_q, dm_a_en_q, dm_a_we_q, dm_b_en_q, dm_b_we_q;
    logic pm_en_q, pm_we_q, pm_ins_en_q, pm_data_vld_q;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    adg_row_s rows [10] = '{
        '{2'h0, 2'h0, 1'b0, 14'h0010}, '{2'h0, 2'h0, 1'b0, 14'h0013},
        '{2'h0, 2'h0, 1'b0, 14'h0016}, '{2'h0, 2'h0, 1'b1, 14'h2200},
        '{2'h1, 2'h1, 1'b0, 14'h0001}, '{2'h1, 2'h1, 1'b0, 14'h3fff},
        '{2'h0, 2'h1, 1'b0, 14'h0014}, '{2'h0, 2'h1, 1'b0, 14'h0012},
        '{2'h0, 2'h1, 1'b0, 14'h0010}, '{2'h0, 2'h0, 1'b0, 14'h0016}};

    adg_core dut (.*);
    adg_pm_model pmem (.*);

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic ld(input logic g, input adg_kind_e k, input logic [1:0] i,
                      input adg_addr_t d);
        @(posedge clk);
        ld_en <= 1'b1;
        ld_gen <= g;
        ld_kind <= k;
        ld_idx <= i;
        ld_data <= d;
        @(posedge clk);
        ld_en <= 1'b0;
    endtask : ld

    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {arst_n, ld_en, ld_gen, rd_gen, a_use, a_brev, a_we, b_use} = '0;
        {b_space, b_we, ab_req, ab_we, fetch_en, px_ld} = '0;
        {ld_idx, rd_idx, a_ptr, a_mod, b_ptr, b_mod, ab_ptr, ab_mod} = '0;
        {ld_data, fetch_addr, core_wdata, px_ld_data} = '0;
        ld_kind = ADG_KIND_PTR;
        rd_kind = ADG_KIND_PTR;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        ld(1'b0, ADG_KIND_PTR, 2'h0, 14'h0010);
        ld(1'b0, ADG_KIND_MOD, 2'h0, 14'h0003);
        ld(1'b0, ADG_KIND_LEN, 2'h0, 14'h0008);
        ld(1'b0, ADG_KIND_PTR, 2'h1, 14'h0001);
        ld(1'b0, ADG_KIND_MOD, 2'h1, 14'h3ffe);
        ld(1'b1, ADG_KIND_PTR, 2'h0, 14'h0040);
        // Back-to-back post-modify, wrap and bit reverse table
        for (int i = 0; i <= 10; i++) begin
            @(posedge clk);
            a_use <= (i < 10);
            if (i < 10) begin
                a_ptr <= rows[i].p;
                a_mod <= rows[i].m;
                a_brev <= rows[i].b;
            end
            #1;
            if (i > 0) chk(dm_a_addr_q, rows[i-1].e);
        end
        repeat (2) @(posedge clk);
        #1 chk(rd_data_q, 14'h0011);
        // Dual operand, fetch, program write and refused serial request
        @(posedge clk);
        px_ld <= 1'b1;
        px_ld_data <= 8'h5c;
        @(posedge clk);
        px_ld_data <= 8'h11;
        {b_use, b_space, b_we, a_use, ab_req, fetch_en} <= 6'h3f;
        {a_brev, a_ptr, a_mod} <= {1'b0, 2'h2, 2'h2};
        core_wdata <= 16'hbeef;
        fetch_addr <= 14'h0123;
        @(posedge clk);
        {px_ld, b_use, b_we, a_use, fetch_en} <= '0;
        #1 chk(pm_wdata_q, 24'hbeef5c);
        chk({pm_en_q, pm_we_q, dm_a_en_q, pm_ins_en_q, ab_grant_q},
            5'h1e);
        chk(pm_ins_addr_q, 14'h0123);
        chk({pm_address_bus_q, pm_low_byte_ext_q}, {14'h0040, 8'h11});
        @(posedge clk);
        ab_req <= 1'b0;
        b_use <= 1'b1;
        #1 chk(ab_grant_q, 1'b1);
        @(posedge clk);
        b_space <= `ADG_SPC_DM;
        #1 chk({pm_en_q, pm_we_q}, 2'h2);
        @(posedge clk);
        b_use <= 1'b0;
        #1 chk({dm_b_en_q, dm_b_we_q, pm_en_q, dm_b_addr_q},
               {3'h4, 14'h0040});
        @(posedge clk);
        #1 chk({pm_data_vld_q, pm_data_q, pm_low_byte_ext_q},
               25'h1beef5c);
        // Reset in mid-run clears outputs and pointers
        @(posedge clk);
        arst_n <= 1'b0;
        #1 chk({pm_low_byte_ext_q, dm_a_en_q, pm_en_q, ab_grant_q},
               11'h000);
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(rd_data_q, 14'h0000);
        summarize();
    end
endmodule : dual_address_generator_bench

bind adg_core adg_core_props props (.*);
